// ---- aivc_map.svh ----
// Operation
// - A 1 V input codes as 0, 4 V as 20736 and 5 V as 27648, linear between.
// - Word format passes -4864..32511, else saturates to 32767 or -32768.
// - Legacy overflow gives overrange end plus one and the overflow bit.
// - Legacy underflow gives undershoot end minus one and the overflow bit.
// - After startup or new parameters, 7fff stands until a conversion.
// - Before or with invalid parameters, both formats show 7fff.
// - Without load supply, 7fff is shown in run and in stop alike.
// - In stop with load supply present, live process values keep flowing.
// - All values are two's complement with the sign in bit 15.
// - A channel disabled by parameter always returns 7fff.
// - Process values of the channels refresh on a fixed 250 ms cycle.
`ifndef AIVC_MAP_SVH
`define AIVC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// scaling: code = (mv - 1000) * 864 / 125
`define AIVC_OFFSET_MV 32'sd1000
`define AIVC_SCALE_NUM 32'sd864
`define AIVC_SCALE_DEN 32'sd125

////////////////////////////////////////////////////////////////////////////////
// range limits and substitute codes
`define AIVC_OVR_MAX 32'sd32511
`define AIVC_UND_MIN -32'sd4864
`define AIVC_POS_SAT 16'h7fff
`define AIVC_NEG_SAT 16'h8000
`define AIVC_LEG_OVR 16'h7f00
`define AIVC_LEG_UND 16'hecff
`define AIVC_INVALID 16'h7fff

////////////////////////////////////////////////////////////////////////////////
// timing
`define AIVC_CYCLE_MS 250
`define AIVC_CLK_KHZ 50000
`define AIVC_CYCLE_CLKS (`AIVC_CYCLE_MS * `AIVC_CLK_KHZ)

`endif

// ---- aivc_pkg.sv ----
package aivc_pkg;

    typedef enum logic {
        aivc_fmt_word,
        aivc_fmt_legacy
    } aivc_fmt_t;

    typedef enum logic [1:0] {
        aivc_rng_in,
        aivc_rng_over,
        aivc_rng_under
    } aivc_range_t;

    typedef struct packed {
        logic [31:0] cycle_cnt;
        logic [1:0] load_sync;
        logic [1:0] have_conv;
        logic [1:0][15:0] sample;
        logic [1:0] sample_ovf;
        logic [1:0][15:0] value;
        logic [1:0] ovf;
        logic upd;
    } aivc_state_t;

endpackage

// ---- aivc_conv_if.sv ----
`timescale 1ns/100ps
interface aivc_conv_if #(
    parameter int MV_W = 14
);
    logic [MV_W-1:0] mv;
    aivc_pkg::aivc_fmt_t fmt;
    logic [15:0] word;
    logic ovf;

    modport conv (input mv, input fmt, output word, output ovf);
    modport user (output mv, output fmt, input word, input ovf);
endinterface

// ---- aivc_scaler.sv ----
`timescale 1ns/100ps
`include "aivc_map.svh"
module aivc_scaler #(
    parameter int MV_W = 14
) (
    // converter side
    aivc_conv_if.conv conv
);

    logic signed [31:0] diff;
    logic signed [31:0] code;
    aivc_pkg::aivc_range_t rng;

    generate
        if (MV_W < 13 || MV_W > 20) begin : g_chk
            $error("aivc_scaler: MV_W must lie in 13..20");
        end
    endgenerate

    always_comb begin
        diff = $signed({{(32 - MV_W){1'b0}}, conv.mv}) - `AIVC_OFFSET_MV;
        code = (diff * `AIVC_SCALE_NUM) / `AIVC_SCALE_DEN;
        if (code > `AIVC_OVR_MAX) begin
            rng = aivc_pkg::aivc_rng_over;
        end else if (code < `AIVC_UND_MIN) begin
            rng = aivc_pkg::aivc_rng_under;
        end else begin
            rng = aivc_pkg::aivc_rng_in;
        end
    end

    // two's complement word, sign in bit 15
    always_comb begin
        conv.ovf = 1'b0;
        conv.word = code[15:0];
        unique case (rng)
            aivc_pkg::aivc_rng_over: begin
                if (conv.fmt == aivc_pkg::aivc_fmt_legacy) begin
                    conv.word = `AIVC_LEG_OVR;
                    conv.ovf = 1'b1;
                end else begin
                    conv.word = `AIVC_POS_SAT;
                end
            end
            aivc_pkg::aivc_rng_under: begin
                if (conv.fmt == aivc_pkg::aivc_fmt_legacy) begin
                    conv.word = `AIVC_LEG_UND;
                    conv.ovf = 1'b1;
                end else begin
                    conv.word = `AIVC_NEG_SAT;
                end
            end
            aivc_pkg::aivc_rng_in: begin
                conv.word = code[15:0];
            end
            default: begin
                conv.word = `AIVC_INVALID;
            end
        endcase
    end

endmodule // aivc_scaler

// ---- aivc_top.sv ----
`timescale 1ns/100ps
`include "aivc_map.svh"
module aivc_top #(
    parameter int MV_W = 14,
    parameter int unsigned CYCLE_CLKS = `AIVC_CYCLE_CLKS
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // converter samples, millivolts, same clock
    input wire logic [MV_W-1:0] ch0_mv_in,
    input wire logic [MV_W-1:0] ch1_mv_in,
    // parameter assignment, same clock
    input wire logic [1:0] ch_enable_in,
    input wire logic param_valid_in,
    input wire logic param_done_in,
    input wire logic fmt_legacy_in,
    // load supply indication pin
    input wire logic load_ok_in,
    // process values
    output logic [15:0] ch0_value_out,
    output logic [15:0] ch1_value_out,
    output logic [1:0] ch_ovf_out,
    output logic value_upd_out
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    generate
        if (CYCLE_CLKS < 1) begin : g_chk_cycle
            $error("aivc_top: CYCLE_CLKS must be at least 1");
        end
        if (MV_W < 13 || MV_W > 20) begin : g_chk_mv
            $error("aivc_top: MV_W must lie in 13..20");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // last count of the refresh cycle
    function automatic logic is_last(
        input logic [31:0] cnt,
        input logic [31:0] last
    );
        logic res;
        res = (cnt == last);
        return res;
    endfunction

    // refresh counter runs freely and wraps at the last count
    function automatic logic [31:0] next_count(
        input logic [31:0] cnt,
        input logic wrap
    );
        logic [31:0] res;
        if (wrap) begin
            res = 32'h0000_0000;
        end else begin
            res = cnt + 32'h0000_0001;
        end
        return res;
    endfunction

    // new or broken parameters discard the last conversion
    function automatic logic must_forget(
        input logic done,
        input logic params_ok
    );
        logic res;
        res = done || !params_ok;
        return res;
    endfunction

    // any one of these reasons puts the invalid code on a channel
    function automatic logic must_subst(
        input logic enabled,
        input logic params_ok,
        input logic load_ok,
        input logic converted
    );
        logic res;
        res = !enabled
              || !params_ok
              || !load_ok
              || !converted;
        return res;
    endfunction

    // value shown to the controller: live sample or the invalid code
    function automatic logic [15:0] shown(
        input logic sub,
        input logic [15:0] smp
    );
        logic [15:0] res;
        if (sub) begin
            res = `AIVC_INVALID;
        end else begin
            res = smp;
        end
        return res;
    endfunction

    // overflow bit never rides along with the invalid code
    function automatic logic shown_flag(
        input logic sub,
        input logic flag
    );
        logic res;
        if (sub) begin
            res = 1'b0;
        end else begin
            res = flag;
        end
        return res;
    endfunction

    // output format as seen by the scalers
    function automatic aivc_pkg::aivc_fmt_t fmt_of(
        input logic legacy
    );
        aivc_pkg::aivc_fmt_t res;
        if (legacy) begin
            res = aivc_pkg::aivc_fmt_legacy;
        end else begin
            res = aivc_pkg::aivc_fmt_word;
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // per-channel converters

    logic [1:0][MV_W-1:0] mv_in;
    logic [1:0][15:0] conv_word;
    logic [1:0] conv_ovf;
    aivc_pkg::aivc_fmt_t fmt;

    assign mv_in[0] = ch0_mv_in;
    assign mv_in[1] = ch1_mv_in;
    assign fmt = fmt_of(fmt_legacy_in);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            aivc_conv_if #(.MV_W(MV_W)) conv_bus ();

            assign conv_bus.mv = mv_in[g];
            assign conv_bus.fmt = fmt;
            assign conv_word[g] = conv_bus.word;
            assign conv_ovf[g] = conv_bus.ovf;

            aivc_scaler #(.MV_W(MV_W)) u_scaler (
                .conv(conv_bus.conv)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // state

    // counter wraps here, so the refresh period is exactly CYCLE_CLKS
    localparam logic [31:0] CYCLE_LAST = 32'(CYCLE_CLKS - 1);

    aivc_pkg::aivc_state_t state;
    aivc_pkg::aivc_state_t next_state;
    logic tick;
    logic subst;
    logic forget;

    always_comb begin
        next_state = state;
        tick = is_last(state.cycle_cnt, CYCLE_LAST);
        forget = must_forget(param_done_in, param_valid_in);
        subst = 1'b0;
        // load pin: only the second stage is read
        next_state.load_sync = {state.load_sync[0], load_ok_in};
        // fixed refresh cycle
        next_state.cycle_cnt = next_count(state.cycle_cnt, tick);
        next_state.upd = tick;
        for (int ch = 0; ch < 2; ch++) begin
            // capture: done beats a tick in the same cycle
            if (forget) begin
                // a fresh assignment waits for a fresh conversion
                next_state.have_conv[ch] = 1'b0;
            end else if (tick) begin
                next_state.sample[ch] = conv_word[ch];
                next_state.sample_ovf[ch] = conv_ovf[ch];
                next_state.have_conv[ch] = 1'b1;
            end
            // run or stop does not matter, only the enable, the supply, params and a captured conversion
            subst = must_subst(ch_enable_in[ch], param_valid_in,
                               state.load_sync[1], state.have_conv[ch]);
            next_state.value[ch] = shown(subst, state.sample[ch]);
            next_state.ovf[ch] = shown_flag(subst, state.sample_ovf[ch]);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state.cycle_cnt <= 32'h0000_0000;
            state.load_sync <= 2'h0;
            state.have_conv <= 2'h0;
            state.sample <= {2{`AIVC_INVALID}};
            state.sample_ovf <= 2'h0;
            state.value <= {2{`AIVC_INVALID}};
            state.ovf <= 2'h0;
            state.upd <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // every output is a bare flop of the state struct
    assign ch0_value_out = state.value[0];
    assign ch1_value_out = state.value[1];
    assign ch_ovf_out = state.ovf;
    assign value_upd_out = state.upd;

endmodule // aivc_top

// ---- aivc_props.sv ----
`timescale 1ns/100ps
module aivc_props #(
    parameter int MV_W = 14,
    parameter int unsigned CYCLE_CLKS = 8
) (
    // inputs
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [MV_W-1:0] ch0_mv_in,
    input wire logic [MV_W-1:0] ch1_mv_in,
    input wire logic [1:0] ch_enable_in,
    input wire logic param_valid_in,
    input wire logic param_done_in,
    input wire logic fmt_legacy_in,
    input wire logic load_ok_in,
    // outputs
    input wire logic [15:0] ch0_value_out,
    input wire logic [15:0] ch1_value_out,
    input wire logic [1:0] ch_ovf_out,
    input wire logic value_upd_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic [31:0] gap;
    logic seen;
    // cycles since the last refresh pulse
    always_ff @(posedge core_clk_in) begin
        gap <= (rst_in || value_upd_out) ? 32'h0 : gap + 32'h1;
        seen <= !rst_in && (seen || value_upd_out);
    end
    sequence load_gone;
        !load_ok_in [*4];
    endsequence
    sequence both_inv;
        ch0_value_out == 16'h7fff && ch1_value_out == 16'h7fff;
    endsequence
    upd_period_a:
        assert property (value_upd_out && seen |-> gap == CYCLE_CLKS - 1)
        else $error("refresh period wrong");
    upd_pulse_a:
        assert property (value_upd_out |=> !value_upd_out)
        else $error("refresh pulse too long");
    ch0_off_a:
        assert property (!ch_enable_in[0] [*2] |-> ch0_value_out == 16'h7fff)
        else $error("disabled ch0 not invalid");
    ch1_off_a:
        assert property (!ch_enable_in[1] [*2] |-> ch1_value_out == 16'h7fff)
        else $error("disabled ch1 not invalid");
    param_bad_a:
        assert property (!param_valid_in [*2]
            |-> both_inv ##0 ch_ovf_out == 2'h0)
        else $error("invalid params not substituted");
    load_gone_a:
        assert property (load_gone |-> both_inv)
        else $error("missing load not substituted");
    done_inv_a:
        assert property (param_done_in |-> ##2 both_inv)
        else $error("no invalid code after assignment");
    start_inv_a:
        assert property ($fell(rst_in) |-> both_inv)
        else $error("no invalid code after reset");
    leg_ovf_a:
        assert property (ch_ovf_out[0]
            |-> ch0_value_out inside {16'h7f00, 16'hecff})
        else $error("overflow bit with wrong value");
endmodule // aivc_props
bind aivc_top aivc_props #(.MV_W(MV_W), .CYCLE_CLKS(CYCLE_CLKS))
    i_aivc_props (.*);

// ---- aivc_cpu_model.sv ----
`timescale 1ns/100ps
module aivc_cpu_model (
    // backplane side
    input wire logic clk_in,
    input wire logic upd_in,
    input wire logic [15:0] ch0_in,
    input wire logic [15:0] ch1_in,
    // values read
    output logic [15:0] rd0_out,
    output logic [15:0] rd1_out,
    output logic [7:0] reads_out = 8'h0
);
    logic pend = 1'h0;
    // read one cycle after the pulse, once the value has landed
    always @(posedge clk_in) begin
        pend <= upd_in;
        if (pend) begin
            rd0_out <= ch0_in;
            rd1_out <= ch1_in;
            reads_out <= reads_out + 8'h1;
        end
    end
endmodule // aivc_cpu_model

// ---- aivc_tb_top.sv ----
`timescale 1ns/100ps
module aivc_tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [13:0] mv0 = 14'h0;
    logic [13:0] mv1 = 14'h0;
    logic [1:0] en = 2'h3;
    logic pv = 1'h1;
    logic pd = 1'h0;
    logic leg = 1'h0;
    logic lok = 1'h1;
    logic [15:0] v0, v1, r0, r1;
    logic [1:0] ovf;
    logic upd;
    logic [7:0] nrd;
    int err_count = 0;
    int cmp_count = 0;
    always #10 clk = ~clk;
    aivc_top #(.CYCLE_CLKS(8)) i_aivc_top (.core_clk_in(clk),
        .rst_in(rst), .ch0_mv_in(mv0), .ch1_mv_in(mv1), .ch_enable_in(en),
        .param_valid_in(pv), .param_done_in(pd), .fmt_legacy_in(leg),
        .load_ok_in(lok), .ch0_value_out(v0), .ch1_value_out(v1),
        .ch_ovf_out(ovf), .value_upd_out(upd));
    aivc_cpu_model i_aivc_cpu_model (.clk_in(clk), .upd_in(upd),
        .ch0_in(v0), .ch1_in(v1), .rd0_out(r0), .rd1_out(r1),
        .reads_out(nrd));
    task automatic complete_run;
        $display("mismatches %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] ex, got);
        cmp_count++;
        if (ex !== got) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // wait for two controller reads so a whole cycle saw the inputs
    task automatic conv(input logic [13:0] a, b, input logic l,
            input logic [15:0] ea, eb, input logic [1:0] eo);
        logic [7:0] t;
        mv0 <= a;
        mv1 <= b;
        leg <= l;
        t = nrd + 8'h2;
        for (int i = 0; i < 40 && nrd !== t; i++) @(posedge clk);
        if (nrd !== t) begin
            $display("ERROR reads expected %h seen %h", t, nrd);
            err_count++;
            complete_run();
        end
        chk("ch0", ea, r0);
        chk("ch1", eb, r1);
        chk("ovf", {14'h0, eo}, {14'h0, ovf});
    endtask
    task automatic t_scale;
        conv(14'h3e8, 14'hfa0, 1'h0, 16'h0, 16'h5100, 2'h0);
        conv(14'h1388, 14'h1647, 1'h0, 16'h6c00, 16'h7efb, 2'h0);
        conv(14'h1648, 14'h128, 1'h0, 16'h7fff, 16'h8000, 2'h0);
        conv(14'h129, 14'h0, 1'h0, 16'hed05, 16'h8000, 2'h0);
        conv(14'h1648, 14'h128, 1'h1, 16'h7f00, 16'hecff, 2'h3);
        $display("scaling done");
    endtask
    task automatic t_load;
        lok <= 1'h0;
        cyc(5);
        chk("ch1", 16'h7fff, v1);
        chk("ch0", 16'h7fff, v0);
        chk("ovf", 16'h0, {14'h0, ovf});
        lok <= 1'h1;
        cyc(5);
        chk("ch1", 16'hecff, v1);
        chk("ch0", 16'h7f00, v0);
        chk("ovf", 16'h3, {14'h0, ovf});
        $display("load done");
    endtask
    task automatic t_param;
        pv <= 1'h0;
        cyc(3);
        chk("ch0", 16'h7fff, v0);
        chk("ovf", 16'h0, {14'h0, ovf});
        pv <= 1'h1;
        conv(14'h1648, 14'h128, 1'h1, 16'h7f00, 16'hecff, 2'h3);
        pd <= 1'h1;
        cyc(1);
        pd <= 1'h0;
        cyc(2);
        chk("ch0", 16'h7fff, v0);
        conv(14'h3e8, 14'h3e8, 1'h0, 16'h0, 16'h0, 2'h0);
        $display("param done");
    endtask
    task automatic t_off;
        en <= 2'h1;
        conv(14'h1388, 14'h1388, 1'h0, 16'h6c00, 16'h7fff, 2'h0);
        en <= 2'h2;
        conv(14'h1648, 14'h129, 1'h1, 16'h7fff, 16'hed05, 2'h0);
        en <= 2'h3;
        $display("disable done");
    endtask
    task automatic t_reset;
        cyc(2);
        chk("ch0", 16'h7fff, v0);
        chk("ch1", 16'h7fff, v1);
        chk("ovf", 16'h0, {14'h0, ovf});
        $display("reset done");
    endtask
    initial begin
        cyc(20);
        rst <= 1'h0;
        t_reset();
        t_scale();
        t_load();
        t_param();
        t_off();
        complete_run();
    end
endmodule // aivc_tb_top
